/* File: hdl/vic_pkg.sv */
// Summary of operation
// - Timers feed requests 0,2,5; port edges 1,3,4.
// - Request 0 highest; vector at 2n+2, 2n+3.
// - Requests 6 and 7 never raised.
// - External requests detected as port line transitions.
// - Some sources always set, others only when configured.
// - Mask bits 0 to 5 enable each request.
// - Mask bit 7 gates every request.
// - Enable instruction sets, disable clears, master enable.
// - Entering service clears master; return sets it.
// - Mask resets to zero; all bits read/write.
// - Events set sticky pending bits 0 to 5.
// - Software write to pending beats same-cycle events.
// - Vector only if enabled and nothing higher both pending and enabled.
// - Pending register resets to zero.
package vic_pkg;
	// ************************************************************
	// Register map and layout.
	// ************************************************************
	localparam logic [7:0] VIC_MASK_ADDR = 8'hFB;
	localparam logic [7:0] VIC_PEND_ADDR = 8'hFA;
	localparam logic [7:0] VIC_MASK_RESET = 8'h00;
	localparam logic [7:0] VIC_PEND_RESET = 8'h00;
	localparam int VIC_NUM_REQ = 6;
	localparam int VIC_MASTER_BIT = 7;
	localparam logic [5:0] VIC_PEND_WMASK = 6'h3F;
	// ************************************************************
	// Request numbering and vectors.
	// ************************************************************
	localparam int VIC_REQ_TMR0 = 0;
	localparam int VIC_REQ_PB4_FALL = 1;
	localparam int VIC_REQ_TMR1 = 2;
	localparam int VIC_REQ_PB2_FALL = 3;
	localparam int VIC_REQ_PB4_RISE = 4;
	localparam int VIC_REQ_TMR2 = 5;
	localparam logic [7:0] VIC_VECTOR_BASE = 8'h02;
	localparam logic [7:0] VIC_VECTOR_STEP = 8'h02;
endpackage

/* File: hdl/vic_top.sv */
`timescale 1ns/1ps
module vic_top (
	// Clock and reset.
	input wire logic mclk_i,
	input wire logic rst_n_i,
	// Register file access from the core.
	input wire logic [7:0] reg_addr_i,
	input wire logic [7:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	output logic [7:0] reg_rdata_o,
	// Interrupt instructions and service entry.
	input wire logic enable_interrupts_instr_i,
	input wire logic disable_interrupts_instr_i,
	input wire logic interrupt_return_instr_i,
	input wire logic vector_ack_i,
	// Request and vector to the core.
	output logic irq_o,
	output logic [2:0] irq_num_o,
	output logic [7:0] vector_addr_o,
	// Sources.
	input wire logic first_timer_timeout_i,
	input wire logic second_timer_timeout_i,
	input wire logic third_timer_timeout_i,
	input wire logic third_timer_int_en_i,
	input wire logic port_b_line_four_i,
	input wire logic port_b_line_two_i
);
	import vic_pkg::*;

	// ************************************************************
	// Helpers.
	// ************************************************************
	function automatic logic [2:0] vic_prio_enc(input logic [5:0] req);
		logic [2:0] idx;
		idx = 3'h0;
		for (int i = VIC_NUM_REQ - 1; i >= 0; i--) begin
			if (req[i]) begin
				idx = 3'(i);
			end
		end
		return idx;
	endfunction

	function automatic logic [7:0] vic_vector(input logic [2:0] num);
		return VIC_VECTOR_BASE + 8'(VIC_VECTOR_STEP * num);
	endfunction

	// Shared by the write strobes and the read mux, so both see one decode.
	function automatic logic vic_addr_hit(input logic [7:0] addr, input logic [7:0] target);
		return addr == target;
	endfunction

	// ************************************************************
	// State.
	// ************************************************************
	logic [7:0] interrupt_enable_mask_r;
	logic [7:0] interrupt_enable_mask_nxt;
	logic [5:0] pending_request_reg_r;
	logic [5:0] pending_request_reg_nxt;
	logic pb4_prev_r;
	logic pb2_prev_r;
	logic primed_r;
	logic [7:0] rdata_r;

	// ************************************************************
	// Source events.
	// ************************************************************
	// Edge detection is held off for the first cycle after reset, so a line
	// that is already high is not taken for a rising edge.
	wire pb4_fall = primed_r & pb4_prev_r & ~port_b_line_four_i;
	wire pb4_rise = primed_r & ~pb4_prev_r & port_b_line_four_i;
	wire pb2_fall = primed_r & pb2_prev_r & ~port_b_line_two_i;
	wire [5:0] src_event = {third_timer_timeout_i & third_timer_int_en_i,
		pb4_rise, pb2_fall, second_timer_timeout_i, pb4_fall, first_timer_timeout_i};

	// ************************************************************
	// Arbitration.
	// ************************************************************
	wire master_en = interrupt_enable_mask_r[VIC_MASTER_BIT];
	wire [5:0] eligible = pending_request_reg_r & interrupt_enable_mask_r[5:0];
	wire [2:0] win_num = vic_prio_enc(eligible);
	wire take_vector = irq_o & vector_ack_i;
	wire [5:0] win_onehot = 6'(6'h01 << win_num);
	// Addresses other than the two registers read as zero and ignore writes.
	wire sel_mask = vic_addr_hit(reg_addr_i, VIC_MASK_ADDR);
	wire sel_pend = vic_addr_hit(reg_addr_i, VIC_PEND_ADDR);
	wire wr_mask = reg_wr_i && sel_mask;
	wire wr_pend = reg_wr_i && sel_pend;

	assign irq_o = master_en & (|eligible);
	assign irq_num_o = win_num;
	assign vector_addr_o = vic_vector(win_num);

	// ************************************************************
	// Next state.
	// ************************************************************
	always_comb begin
		interrupt_enable_mask_nxt = interrupt_enable_mask_r;
		if (wr_mask) begin
			interrupt_enable_mask_nxt = reg_wdata_i;
		end
		// Instructions act after a same-cycle write, so the master bit follows them.
		if (take_vector || disable_interrupts_instr_i) begin
			interrupt_enable_mask_nxt[VIC_MASTER_BIT] = 1'b0;
		end else if (enable_interrupts_instr_i || interrupt_return_instr_i) begin
			interrupt_enable_mask_nxt[VIC_MASTER_BIT] = 1'b1;
		end
	end

	always_comb begin
		// Events are merged after the service clear, so an event that lands in the cycle
		// of its own vector fetch stays pending for a second service instead of being lost.
		pending_request_reg_nxt = pending_request_reg_r;
		if (take_vector) begin
			pending_request_reg_nxt = pending_request_reg_nxt & ~win_onehot;
		end
		pending_request_reg_nxt = pending_request_reg_nxt | src_event;
		if (wr_pend) begin
			// Software writeback wins; a same-cycle event is dropped.
			pending_request_reg_nxt = reg_wdata_i[5:0] & VIC_PEND_WMASK;
		end
	end

	wire [7:0] rd_mux = sel_mask ? interrupt_enable_mask_r :
		sel_pend ? {2'b00, pending_request_reg_r} : 8'h00;

	// ************************************************************
	// Registers.
	// ************************************************************
	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			interrupt_enable_mask_r <= VIC_MASK_RESET;
			pending_request_reg_r <= VIC_PEND_RESET[5:0];
		end else begin
			interrupt_enable_mask_r <= interrupt_enable_mask_nxt;
			pending_request_reg_r <= pending_request_reg_nxt;
		end
	end

	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			pb4_prev_r <= 1'b0;
			pb2_prev_r <= 1'b0;
			primed_r <= 1'b0;
			rdata_r <= 8'h00;
		end else begin
			pb4_prev_r <= port_b_line_four_i;
			pb2_prev_r <= port_b_line_two_i;
			primed_r <= 1'b1;
			if (reg_rd_i) begin
				rdata_r <= rd_mux;
			end
		end
	end

	assign reg_rdata_o = rdata_r;

	// ************************************************************
	// Checks.
	// ************************************************************
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (!rst_n_i);

	a_tmr0_sets_pend: assert property (first_timer_timeout_i && !wr_pend |=> pending_request_reg_r[0])
		else $error("timer zero event did not set pending bit");
	a_pb4_fall_sets: assert property (primed_r && $fell(port_b_line_four_i) && !wr_pend
		|=> pending_request_reg_r[1])
		else $error("falling edge on line four missed");
	a_tmr2_gated_cfg: assert property (third_timer_timeout_i && !third_timer_int_en_i
		&& !pending_request_reg_r[5] && !wr_pend |=> !pending_request_reg_r[5])
		else $error("unconfigured timer set its request");
	a_irq_needs_master: assert property (irq_o |-> interrupt_enable_mask_r[7])
		else $error("request raised with master enable clear");
	a_prio_highest_wins: assert property (irq_o && eligible[0] |-> vector_addr_o == 8'h02)
		else $error("highest request not chosen");
	a_vector_pairs: assert property (irq_o |-> vector_addr_o == 8'(2 * irq_num_o + 2) && irq_num_o < 3'h6)
		else $error("vector address mismatch");
	a_mask_gates_req: assert property (irq_o |-> interrupt_enable_mask_r[irq_num_o])
		else $error("masked request selected");
	a_service_clears: assert property (take_vector && !wr_mask && !wr_pend && !enable_interrupts_instr_i
		&& !interrupt_return_instr_i && !src_event[irq_num_o]
		|=> !interrupt_enable_mask_r[7] && !pending_request_reg_r[$past(irq_num_o)])
		else $error("service entry did not clear master and pending");
	a_ei_sets_master: assert property (enable_interrupts_instr_i && !disable_interrupts_instr_i
		&& !vector_ack_i |=> interrupt_enable_mask_r[7])
		else $error("enable instruction did not set master");
	a_write_wins: assert property (wr_pend |=> pending_request_reg_r == $past(reg_wdata_i[5:0]))
		else $error("pending write did not take precedence");
	a_pend_sticky: assert property (pending_request_reg_r[3] && !wr_pend && !take_vector
		|=> pending_request_reg_r[3])
		else $error("pending bit dropped without write");
	a_tmr1_sets_pend: assert property (second_timer_timeout_i && !wr_pend |=> pending_request_reg_r[2])
		else $error("timer one event did not set pending bit");
	a_tmr2_sets_cfg: assert property (third_timer_timeout_i && third_timer_int_en_i && !wr_pend
		|=> pending_request_reg_r[5])
		else $error("configured timer two event did not set pending bit");
	a_pb4_rise_sets: assert property (primed_r && $rose(port_b_line_four_i) && !wr_pend
		|=> pending_request_reg_r[4])
		else $error("rising edge on line four missed");
	a_pb2_fall_sets: assert property (primed_r && $fell(port_b_line_two_i) && !wr_pend
		|=> pending_request_reg_r[3])
		else $error("falling edge on line two missed");
	a_set_beats_ack: assert property (take_vector && src_event[irq_num_o] && !wr_pend
		|=> pending_request_reg_r[$past(irq_num_o)])
		else $error("event lost behind its own service entry");
	a_di_clears_master: assert property (disable_interrupts_instr_i |=> !interrupt_enable_mask_r[7])
		else $error("disable instruction left master set");
	a_interrupt_return_instr_sets_master: assert property (interrupt_return_instr_i && !disable_interrupts_instr_i
		&& !take_vector |=> interrupt_enable_mask_r[7])
		else $error("return instruction did not set master");
	a_mask_write_lands: assert property (wr_mask && !take_vector && !disable_interrupts_instr_i
		&& !enable_interrupts_instr_i && !interrupt_return_instr_i
		|=> interrupt_enable_mask_r == $past(reg_wdata_i))
		else $error("mask write did not land");
	a_pend_top_zero: assert property (reg_rd_i && sel_pend |=> reg_rdata_o[7:6] == 2'b00)
		else $error("reserved pending bits read nonzero");

	c_vector_taken: cover property (take_vector);
	c_nested_two: cover property (irq_o && eligible[0] && eligible[5]);
	c_write_collides: cover property (wr_pend && |src_event);
	c_interrupt_return_instr_reenables: cover property (interrupt_return_instr_i ##1 irq_o);
	c_event_meets_ack: cover property (take_vector && |src_event);
endmodule

/* File: verif/vic_core_model.sv */
`timescale 1ns/1ps
module vic_core_model (
	// Clock.
	input wire logic mclk_i,
	// Bench control and request from the controller.
	input wire logic take_i,
	input wire logic irq_i,
	// Service entry to the controller.
	output logic vector_ack_o
);
	// ************************************************************
	// Service entry.
	// ************************************************************
	// The core acknowledges one pending request per command and never acknowledges an idle line.
	initial vector_ack_o = 1'b0;
	always @(negedge mclk_i) begin
		vector_ack_o <= take_i && irq_i && !vector_ack_o;
	end
endmodule

/* File: verif/vic_top_bench.sv */
`timescale 1ns/1ps
module vic_top_bench;
	import vic_pkg::*;
	logic mclk_i = 0, rst_n_i = 0, wr = 0, rd = 0, ei = 0, di = 0, interrupt_return_instr = 0, t0 = 0, t1 = 0, t2 = 0;
	logic t2en = 1, pb4 = 1, pb2 = 1, take = 0, ack, irq;
	logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, vec;
	logic [2:0] num;
	int n_fail = 0, n_compared = 0;
	vic_top uut (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr),
		.reg_rd_i(rd), .reg_rdata_o(rdata), .enable_interrupts_instr_i(ei), .disable_interrupts_instr_i(di),
		.interrupt_return_instr_i(interrupt_return_instr), .vector_ack_i(ack), .irq_o(irq), .irq_num_o(num), .vector_addr_o(vec),
		.first_timer_timeout_i(t0), .second_timer_timeout_i(t1), .third_timer_timeout_i(t2),
		.third_timer_int_en_i(t2en), .port_b_line_four_i(pb4), .port_b_line_two_i(pb2));
	vic_core_model core (.mclk_i(mclk_i), .take_i(take), .irq_i(irq), .vector_ack_o(ack));
	// ************************************************************
	// Access tasks.
	// ************************************************************
	initial forever #12.5 mclk_i = ~mclk_i;
	task cmp(input logic [7:0] got, input logic [7:0] exp);
		n_compared++;
		if (got !== exp) begin
			n_fail++;
			$display("unexpected at %0t ns: got %h, expected %h", $time, got, exp);
		end
	endtask
	task wr_reg(input logic [7:0] a, input logic [7:0] d);
		@(negedge mclk_i);
		addr = a;
		wdata = d;
		wr = 1;
		@(negedge mclk_i);
		wr = 0;
	endtask
	task rd_reg(input logic [7:0] a, input logic [7:0] exp);
		@(negedge mclk_i);
		addr = a;
		rd = 1;
		@(negedge mclk_i);
		rd = 0;
		cmp(rdata, exp);
	endtask
	// Codes 0 to 5 fire the sources, 6 enables, 7 disables, 8 returns from service.
	task strobe(input int k);
		@(negedge mclk_i);
		case (k)
			0: t0 = 1;
			1: pb4 = 0;
			2: t1 = 1;
			3: pb2 = 0;
			4: pb4 = 1;
			5: t2 = 1;
			6: ei = 1;
			7: di = 1;
			default: interrupt_return_instr = 1;
		endcase
		@(negedge mclk_i);
		{t0, t1, t2, pb2, ei, di, interrupt_return_instr} = 7'h08;
	endtask
	task irq_chk(input logic i, input logic [2:0] n);
		cmp({7'h00, irq}, {7'h00, i});
		if (i) begin
			cmp({5'h00, num}, {5'h00, n});
			cmp(vec, VIC_VECTOR_BASE + VIC_VECTOR_STEP * n);
		end
	endtask
	task serve;
		@(negedge mclk_i);
		take <= 1;
		@(negedge mclk_i);
		take <= 0;
		repeat (2) @(negedge mclk_i);
	endtask
	task close_out;
		if (n_fail == 0 && n_compared > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	// ************************************************************
	// Tests.
	// ************************************************************
	initial begin
		repeat (3000) @(posedge mclk_i);
		n_fail++;
		close_out;
	end
	initial begin
		repeat (10) @(posedge mclk_i);
		@(negedge mclk_i);
		rst_n_i = 1;
		rd_reg(VIC_MASK_ADDR, 8'h00);
		rd_reg(VIC_PEND_ADDR, 8'h00);
		wr_reg(8'h55, 8'hFF);
		rd_reg(8'h55, 8'h00);
		wr_reg(VIC_MASK_ADDR, 8'h7F);
		rd_reg(VIC_MASK_ADDR, 8'h7F);
		for (int k = 0; k < 6; k++) begin
			strobe(k);
			rd_reg(VIC_PEND_ADDR, 8'h01 << k);
			wr_reg(VIC_PEND_ADDR, 8'h00);
		end
		t2en = 0;
		strobe(5);
		rd_reg(VIC_PEND_ADDR, 8'h00);
		fork
			wr_reg(VIC_PEND_ADDR, 8'h04);
			strobe(0);
		join
		rd_reg(VIC_PEND_ADDR, 8'h04);
		wr_reg(VIC_PEND_ADDR, 8'hFF);
		rd_reg(VIC_PEND_ADDR, 8'h3F);
		irq_chk(0, 0);
		strobe(6);
		for (int k = 0; k < 6; k++) begin
			irq_chk(1, k);
			serve;
			irq_chk(0, 0);
			rd_reg(VIC_MASK_ADDR, 8'h7F);
			rd_reg(VIC_PEND_ADDR, (8'h3F << (k + 1)) & 8'h3F);
			strobe(8);
		end
		strobe(7);
		rd_reg(VIC_MASK_ADDR, 8'h7F);
		wr_reg(VIC_MASK_ADDR, 8'h7E);
		wr_reg(VIC_PEND_ADDR, 8'h03);
		strobe(6);
		irq_chk(1, 1);
		// Reset again with line four high and state loaded, which would show a false rising edge.
		@(negedge mclk_i);
		rst_n_i = 0;
		@(negedge mclk_i);
		irq_chk(0, 0);
		rst_n_i = 1;
		rd_reg(VIC_MASK_ADDR, 8'h00);
		rd_reg(VIC_PEND_ADDR, 8'h00);
		close_out;
	end
endmodule
